//--- hdl/bcs_exec_regs.svh
/*
  Register offsets, field positions, opcode patterns and reset values
  for the branch, call and subtract-with-borrow execution block.
  Assumes it is included by its bare name from the design files and the testbench.
*/
`ifndef BCS_EXEC_REGS_SVH
`define BCS_EXEC_REGS_SVH

// ==========================================================================
// Register byte offsets.
`define BCS_OFF_CTRL 8'h00
`define BCS_OFF_INSTR 8'h04
`define BCS_OFF_INSTR2 8'h08
`define BCS_OFF_PC 8'h0c
`define BCS_OFF_WREG 8'h10
`define BCS_OFF_FLAGS 8'h14
`define BCS_OFF_BANK 8'h18
`define BCS_OFF_TOS 8'h1c
`define BCS_OFF_SHADOW 8'h20
`define BCS_OFF_DADDR 8'h24
`define BCS_OFF_DDATA 8'h28
`define BCS_OFF_CYCLES 8'h2c

// ==========================================================================
// Field positions.
`define BCS_CTRL_START 0
`define BCS_CTRL_BUSY 0
`define BCS_CTRL_BAD_OP 1
`define BCS_CTRL_STK_OVF 2
`define BCS_FLAG_C 0
`define BCS_FLAG_DC 1
`define BCS_FLAG_Z 2
`define BCS_FLAG_OV 3
`define BCS_FLAG_N 4

// ==========================================================================
// Opcode patterns, compared against the top bits of the first word; BCS_OP_CALL_HI against those of the second.
`define BCS_OP_BZ 8'he0
`define BCS_OP_CALL 7'h76
`define BCS_OP_SUB 6'h16
`define BCS_OP_CALL_HI 4'hf

// ==========================================================================
// Reset values and constants.
`define BCS_PC_RST 21'h000000
`define BCS_BYTE_RST 8'h00
`define BCS_ACCESS_BANK 4'h0
`define BCS_PC_STEP 21'h000002
`define BCS_CALL_RET 21'h000004

`endif

//--- hdl/bcs_pkg.sv
/*
  Types used by the execution core's sequencer and decoder.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package bcs_pkg;
  // ========================================================================
  // Execution sequencer states.
  typedef enum logic [1:0] {BCS_IDLE, BCS_EXEC, BCS_NOP} bcs_state_t;
  // Decoded instruction class.
  typedef enum logic [1:0] {BCS_INS_NONE, BCS_INS_BZ, BCS_INS_CALL, BCS_INS_SUB} bcs_ins_t;
endpackage
`default_nettype wire

//--- hdl/bcs_core_if.sv
/*
  Carrier between the execution core, its subtractor and its return stack.
  Assumes one clock domain; the modules on each modport share it.
*/
`default_nettype none
interface bcs_core_if;
  logic [7:0] f_val;
  logic [7:0] w_val;
  logic c_in;
  logic [7:0] result;
  logic [4:0] flags;
  logic [4:0] status;
  logic push;
  logic [20:0] push_addr;
  logic save_shadow;
  logic [7:0] bank_val;
  logic [20:0] return_stack_top;
  logic [7:0] shadow_w;
  logic [7:0] shadow_f;
  logic [7:0] shadow_b;
  logic overflow;
  modport core(output f_val, w_val, c_in, push, push_addr, save_shadow, bank_val, status,
    input result, flags, return_stack_top, shadow_w, shadow_f, shadow_b, overflow);
  modport alu(input f_val, w_val, c_in, output result, flags);
  modport stk(input push, push_addr, save_shadow, w_val, status, c_in, bank_val,
    output return_stack_top, shadow_w, shadow_f, shadow_b, overflow);
endinterface
`default_nettype wire

//--- hdl/bcs_alu.sv
/*
  Subtract-with-borrow datapath, purely combinational.
  Assumes the core presents the operands in the cycle the result is used.
*/
`default_nettype none
`include "bcs_exec_regs.svh"
module bcs_alu (
  bcs_core_if.alu bus
);
  logic [8:0] diff;
  logic [4:0] nib;

  // ========================================================================
  // Borrow subtract; a carry of 1 means no borrow, so its inverse is taken.
  always_comb begin
    diff = {1'b0, bus.f_val} - {1'b0, bus.w_val} - {8'h00, ~bus.c_in};
    nib = {1'b0, bus.f_val[3:0]} - {1'b0, bus.w_val[3:0]} - {4'h0, ~bus.c_in};
    bus.result = diff[7:0];
    bus.flags = 5'h00;
    bus.flags[`BCS_FLAG_C] = ~diff[8];
    bus.flags[`BCS_FLAG_DC] = ~nib[4];
    bus.flags[`BCS_FLAG_Z] = (diff[7:0] == 8'h00);
    bus.flags[`BCS_FLAG_N] = diff[7];
    // Overflow when the operands differ in sign and the result left f's sign.
    bus.flags[`BCS_FLAG_OV] = (bus.f_val[7] ^ bus.w_val[7]) & (bus.f_val[7] ^ diff[7]);
  end
endmodule
`default_nettype wire

//--- hdl/bcs_stack.sv
/*
  Hardware return stack and the fast-save shadow registers.
  Assumes push and save_shadow are one-cycle strobes from the core.
*/
`default_nettype none
`include "bcs_exec_regs.svh"
module bcs_stack #(
  parameter int DEPTH = 31
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  bcs_core_if.stk bus
);
  logic [20:0] entries [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] ptr;
  logic [20:0] top;
  logic ovf;
  logic [7:0] sw;
  logic [7:0] sf;
  logic [7:0] sb;

  // ========================================================================
  // Entry storage; a full stack drops the push rather than wrapping.
  always_ff @(posedge clk_in) begin
    if (bus.push && ptr != DEPTH[$bits(ptr)-1:0]) begin
      entries[ptr[$clog2(DEPTH)-1:0]] <= bus.push_addr;
    end
  end

  // Pointer, top copy and sticky overflow.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ptr <= '0;
      top <= `BCS_PC_RST;
      ovf <= 1'b0;
    end else if (bus.push) begin
      if (ptr == DEPTH[$bits(ptr)-1:0]) begin
        ovf <= 1'b1;
      end else begin
        ptr <= ptr + 1'b1;
        top <= bus.push_addr;
      end
    end
  end

  // Shadows change only on a fast-save call.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sw <= `BCS_BYTE_RST;
      sf <= `BCS_BYTE_RST;
      sb <= `BCS_BYTE_RST;
    end else if (bus.save_shadow) begin
      sw <= bus.w_val;
      sf <= {3'h0, bus.status};
      sb <= bus.bank_val;
    end
  end

  assign bus.return_stack_top = top;
  assign bus.shadow_w = sw;
  assign bus.shadow_f = sf;
  assign bus.shadow_b = sb;
  assign bus.overflow = ovf;
endmodule
`default_nettype wire

//--- hdl/bcs_exec.sv
/*
  Execution core for branch-on-zero, two-word call and subtract-with-borrow,
  with an APB slave for loading instructions and viewing the core state.
  Assumes one clock at 10 MHz, one instruction cycle per clock, and an
  APB master that holds its request until it sees PREADY_OUT high.
  Limitation: nothing pops the return stack here, so a full stack drops
  further pushes and only raises a sticky overflow bit for software.
*/
`default_nettype none
`include "bcs_exec_regs.svh"
module bcs_exec #(
  parameter int BANKS = 16,
  parameter int STACK_DEPTH = 31
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT
);
  // Bank number width; a file address is the bank number above an 8-bit offset.
  localparam int BW = $clog2(BANKS);

  // Carrier to the subtractor and the return stack.
  bcs_core_if cif ();
  bcs_pkg::bcs_state_t state;
  bcs_pkg::bcs_ins_t ins;
  logic [15:0] instr;
  logic [15:0] instr2;
  logic [20:0] pc;
  logic [7:0] working;
  logic [4:0] flags;
  logic [7:0] bank_select_reg;
  logic [11:0] daddr;
  logic [7:0] cycles;
  logic bad_op;
  logic [7:0] data_mem [BANKS*256];
  logic [BW+7:0] f_addr;
  logic wr_ok;
  logic start;
  logic exec_now;
  logic [31:0] next_rdata;

  // ========================================================================
  // Helpers.
  // The subtractor is combinational; the stack registers its own state.
  bcs_alu u_alu (
    .bus(cif.alu)
  );
  bcs_stack #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .bus(cif.stk)
  );

  // Register hit test, used by the error answer; the read mux decodes offsets itself.
  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a[1:0] == 2'b00) && (a <= `BCS_OFF_CYCLES);
  endfunction

  // Address of the next instruction word; every fall-through path uses it.
  function automatic logic [20:0] pc_next(input logic [20:0] p);
    pc_next = p + `BCS_PC_STEP;
  endfunction

  // Branch target: the offset is sign-extended and doubled before the add,
  // so the target always stays word aligned.
  function automatic logic [20:0] branch_target(input logic [20:0] p, input logic [7:0] n);
    branch_target = pc_next(p) + {{12{n[7]}}, n, 1'b0};
  endfunction

  // ========================================================================
  // Decode of the first word.
  // A call whose second word lacks the fixed top nibble decodes as unknown,
  // so a half-loaded call never jumps to a garbage target.
  always_comb begin
    if (instr[15:8] == `BCS_OP_BZ) begin
      ins = bcs_pkg::BCS_INS_BZ;
    end else if (instr[15:9] == `BCS_OP_CALL && instr2[15:12] == `BCS_OP_CALL_HI) begin
      ins = bcs_pkg::BCS_INS_CALL;
    end else if (instr[15:10] == `BCS_OP_SUB) begin
      ins = bcs_pkg::BCS_INS_SUB;
    end else begin
      ins = bcs_pkg::BCS_INS_NONE;
    end
  end

  // File address; the access bit picks the common bank or the selected one.
  // Bank bits above the implemented banks are ignored.
  always_comb begin
    if (instr[8]) begin
      f_addr = {bank_select_reg[BW-1:0], instr[7:0]};
    end else begin
      f_addr = {`BCS_ACCESS_BANK, instr[7:0]};
    end
  end

  // Operands to the subtractor and the stack.
  // A call pushes in its execute cycle; the refill cycle pushes nothing.
  assign exec_now = (state == bcs_pkg::BCS_EXEC);
  assign cif.f_val = data_mem[f_addr];
  assign cif.w_val = working;
  assign cif.c_in = flags[`BCS_FLAG_C];
  assign cif.bank_val = bank_select_reg;
  // The shadow copy takes the flags register itself, never the subtractor's output.
  assign cif.status = flags;
  assign cif.push = exec_now && ins == bcs_pkg::BCS_INS_CALL;
  assign cif.push_addr = pc + `BCS_CALL_RET;
  assign cif.save_shadow = cif.push && instr[8];

  // ========================================================================
  // APB strobes; a write lands on the edge where PREADY_OUT is seen high.
  // Taking it there keeps the write and its answer on one and the same edge.
  assign wr_ok = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
  assign start = wr_ok && PADDR_IN == `BCS_OFF_CTRL && PWDATA_IN[`BCS_CTRL_START]
    && state == bcs_pkg::BCS_IDLE;

  // One wait state: the answer is prepared in the first access cycle.
  // PSLVERR_OUT rides with PREADY_OUT for any unmapped or unaligned offset.
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
    end else if (PSEL_IN && PENABLE_IN && !PREADY_OUT) begin
      PREADY_OUT <= 1'b1;
      PSLVERR_OUT <= !reg_known(PADDR_IN);
      // Read data stands until the next read answer, so a write leaves it alone.
      if (!PWRITE_IN) begin
        PRDATA_OUT <= next_rdata;
      end
    end else begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read as zero.
  // Unaligned offsets fall to the default and read as zero too.
  always_comb begin
    next_rdata = 32'h00000000;
    case (PADDR_IN)
      `BCS_OFF_CTRL: next_rdata = {29'h0, cif.overflow, bad_op,
        state != bcs_pkg::BCS_IDLE};
      `BCS_OFF_INSTR: next_rdata = {16'h0000, instr};
      `BCS_OFF_INSTR2: next_rdata = {16'h0000, instr2};
      `BCS_OFF_PC: next_rdata = {11'h000, pc};
      `BCS_OFF_WREG: next_rdata = {24'h000000, working};
      `BCS_OFF_FLAGS: next_rdata = {27'h0000000, flags};
      `BCS_OFF_BANK: next_rdata = {24'h000000, bank_select_reg};
      `BCS_OFF_TOS: next_rdata = {11'h000, cif.return_stack_top};
      `BCS_OFF_SHADOW: next_rdata = {8'h00, cif.shadow_b, cif.shadow_f, cif.shadow_w};
      `BCS_OFF_DADDR: next_rdata = {20'h00000, daddr};
      `BCS_OFF_DDATA: next_rdata = {24'h000000, data_mem[daddr[BW+7:0]]};
      `BCS_OFF_CYCLES: next_rdata = {24'h000000, cycles};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // ========================================================================
  // Instruction words and data address; frozen while an instruction runs.
  // Writes while busy are dropped, so a running instruction never sees a torn pair.
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      instr <= 16'h0000;
      instr2 <= 16'h0000;
      daddr <= 12'h000;
    end else if (wr_ok && state == bcs_pkg::BCS_IDLE) begin
      case (PADDR_IN)
        `BCS_OFF_INSTR: instr <= PWDATA_IN[15:0];
        `BCS_OFF_INSTR2: instr2 <= PWDATA_IN[15:0];
        `BCS_OFF_DADDR: daddr <= PWDATA_IN[11:0];
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Sequencer: a taken branch and a call each add one idle refill cycle.
  // The refill cycle stands for the fetch that the jump throws away.
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      state <= bcs_pkg::BCS_IDLE;
    end else begin
      case (state)
        bcs_pkg::BCS_IDLE: if (start) begin
          state <= bcs_pkg::BCS_EXEC;
        end
        bcs_pkg::BCS_EXEC: begin
          if ((ins == bcs_pkg::BCS_INS_BZ && flags[`BCS_FLAG_Z]) ||
              ins == bcs_pkg::BCS_INS_CALL) begin
            state <= bcs_pkg::BCS_NOP;
          end else begin
            state <= bcs_pkg::BCS_IDLE;
          end
        end
        bcs_pkg::BCS_NOP: state <= bcs_pkg::BCS_IDLE;
        default: state <= bcs_pkg::BCS_IDLE;
      endcase
    end
  end

  // Cycle count of the last instruction, for software to inspect.
  // Eight bits are ample: no instruction here runs longer than two cycles.
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      cycles <= 8'h00;
    end else if (start) begin
      cycles <= 8'h00;
    end else if (state != bcs_pkg::BCS_IDLE) begin
      cycles <= cycles + 8'h01;
    end
  end

  // Sticky flag for a word that is none of the three instructions.
  // Set and clear never meet: a start is taken only while idle.
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      bad_op <= 1'b0;
    end else if (exec_now && ins == bcs_pkg::BCS_INS_NONE) begin
      bad_op <= 1'b1;
    end else if (start) begin
      bad_op <= 1'b0;
    end
  end

  // ========================================================================
  // Program counter; software may set it only while idle.
  // A software write forces bit 0 low, so the counter never holds an odd address.
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      pc <= `BCS_PC_RST;
    end else if (exec_now) begin
      case (ins)
        bcs_pkg::BCS_INS_BZ: begin
          if (flags[`BCS_FLAG_Z]) begin
            // Taken: the refill cycle that follows is spent in the sequencer.
            pc <= branch_target(pc, instr[7:0]);
          end else begin
            pc <= pc_next(pc);
          end
        end
        bcs_pkg::BCS_INS_CALL: pc <= {instr2[11:0], instr[7:0], 1'b0};
        bcs_pkg::BCS_INS_SUB: pc <= pc_next(pc);
        default: pc <= pc_next(pc);
      endcase
    end else if (wr_ok && state == bcs_pkg::BCS_IDLE && PADDR_IN == `BCS_OFF_PC) begin
      pc <= {PWDATA_IN[20:1], 1'b0};
    end
  end

  // Working register.
  // Only a subtract with its destination bit clear writes it; software loads it while idle.
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      working <= `BCS_BYTE_RST;
    end else if (exec_now && ins == bcs_pkg::BCS_INS_SUB && !instr[9]) begin
      working <= cif.result;
    end else if (wr_ok && state == bcs_pkg::BCS_IDLE && PADDR_IN == `BCS_OFF_WREG) begin
      working <= PWDATA_IN[7:0];
    end
  end

  // Flags change only on a subtract; branch and call leave them alone.
  // Software may preset them while idle, which is how a borrow is fed in.
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      flags <= 5'h00;
    end else if (exec_now && ins == bcs_pkg::BCS_INS_SUB) begin
      flags <= cif.flags;
    end else if (wr_ok && state == bcs_pkg::BCS_IDLE && PADDR_IN == `BCS_OFF_FLAGS) begin
      flags <= PWDATA_IN[4:0];
    end
  end

  // Bank select, software owned.
  // Writes while busy are refused, so a file address cannot move under a subtract.
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      bank_select_reg <= `BCS_BYTE_RST;
    end else if (wr_ok && state == bcs_pkg::BCS_IDLE && PADDR_IN == `BCS_OFF_BANK) begin
      bank_select_reg <= PWDATA_IN[7:0];
    end
  end

  // ========================================================================
  // Data memory; left without reset so it maps onto plain RAM.
  // Software must write a byte before a subtract reads it, or the result is unknown.
  always_ff @(posedge CLK_IN) begin
    if (exec_now && ins == bcs_pkg::BCS_INS_SUB && instr[9]) begin
      data_mem[f_addr] <= cif.result;
    end else if (wr_ok && state == bcs_pkg::BCS_IDLE && PADDR_IN == `BCS_OFF_DDATA) begin
      data_mem[daddr[BW+7:0]] <= PWDATA_IN[7:0];
    end
  end
endmodule
`default_nettype wire

//--- test/bcs_exec_monitor.sv
/*
  Protocol and register-view monitor for the execution block's APB port.
  Assumes it is bound to the block's top module and sees only its ports.
*/
`default_nettype none
module bcs_exec_monitor (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mapped;

  // ==========================================================================
  // Transfer steps.
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  // First access cycle, where the slave takes the request.
  sequence s_take;
    PSEL_IN && PENABLE_IN && !PREADY_OUT;
  endsequence
  // Cycle in which read data is handed over.
  sequence s_read_ans;
    PREADY_OUT && !PWRITE_IN;
  endsequence
  // Word aligned and not past the last register; anything else must be refused.
  assign mapped = (PADDR_IN <= 8'h2c) && (PADDR_IN[1:0] == 2'b00);

  // ==========================================================================
  // Checks.
  ready_one_cycle_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held past one cycle");
  ready_after_take_a: assert property (s_take |=> PREADY_OUT)
    else $error("no ready one cycle after access");
  no_stray_ready_a: assert property (!(PSEL_IN && PENABLE_IN) |=> !PREADY_OUT)
    else $error("ready without an access");
  err_with_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error outside a ready cycle");
  unmapped_err_a: assert property (s_take ##0 !mapped |=> PSLVERR_OUT)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (s_take ##0 mapped |=> !PSLVERR_OUT)
    else $error("mapped access refused");
  err_read_zero_a: assert property (s_read_ans ##0 PSLVERR_OUT |-> PRDATA_OUT == 32'h0)
    else $error("refused read returned data");
  rdata_holds_a: assert property ($changed(PRDATA_OUT) |-> PREADY_OUT && !PWRITE_IN)
    else $error("read data moved outside a read answer");
  pc_aligned_a: assert property (
    s_read_ans ##0 (PADDR_IN == 8'h0c) |-> PRDATA_OUT[0] == 1'b0 && PRDATA_OUT[31:21] == 11'h0)
    else $error("counter view not word aligned");
  flags_width_a: assert property (
    s_read_ans ##0 (PADDR_IN == 8'h14) |-> PRDATA_OUT[31:5] == 27'h0)
    else $error("flags view has stray bits");
endmodule
`default_nettype wire

//--- test/testbench.sv
/*
  Self-checking bench for the branch, call and subtract-with-borrow block.
  Assumes the design files and the monitor are compiled before this file.
*/
`default_nettype none
`include "bcs_exec_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [15:0] ins, ins2;
    logic [20:0] pc;
    logic [7:0] w, fl, bk, dd;
    logic [20:0] epc;
    logic [7:0] ew, efl, ecy, edd;
    logic [20:0] etos;
    logic [23:0] esh;
  } bcs_row_t;
  localparam int DEPTH = 31;
  logic CLK_IN = 1'b0;
  logic RESETN_IN = 1'b0;
  logic PSEL_IN = 1'b0;
  logic PENABLE_IN = 1'b0;
  logic PWRITE_IN = 1'b0;
  logic [7:0] PADDR_IN = 8'h00;
  logic [31:0] PWDATA_IN = 32'h0;
  logic [31:0] PRDATA_OUT;
  logic PREADY_OUT;
  logic PSLVERR_OUT;
  int bad_count = 0;
  int n_checks = 0;
  logic [31:0] q;
  logic e;
  logic [11:0] da;
  bcs_row_t rows [10];
  bcs_row_t r;

  bcs_exec #(.STACK_DEPTH(DEPTH)) i_bcs_exec (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT));

  // ==========================================================================
  // Clock, watchdog and verdict.
  initial begin
    forever #50 CLK_IN = ~CLK_IN;
  end
  // The whole run needs about 1200 cycles, so eight times that means a hang.
  initial begin
    repeat (10000) @(posedge CLK_IN);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Bus tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // Leaves the request up, so a second transfer may follow with no idle cycle.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    PSEL_IN <= 1'b1;
    PENABLE_IN <= 1'b0;
    PWRITE_IN <= wr;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    @(posedge CLK_IN);
    PENABLE_IN <= 1'b1;
    do @(posedge CLK_IN); while (PREADY_OUT !== 1'b1);
    q = PRDATA_OUT;
    e = PSLVERR_OUT;
  endtask
  task automatic idle();
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
    @(posedge CLK_IN);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    idle();
    chk(q, exp, m);
  endtask
  // Loads both words, starts, and polls busy a bounded number of times.
  task automatic run(input logic [15:0] i1, input logic [15:0] i2);
    wr(`BCS_OFF_INSTR, 32'(i1));
    wr(`BCS_OFF_INSTR2, 32'(i2));
    wr(`BCS_OFF_CTRL, 32'h1);
    for (int k = 0; k < 20; k++) begin
      apb(1'b0, `BCS_OFF_CTRL, 32'h0);
      idle();
      if (q[0] === 1'b0) break;
    end
    chk(32'(q[0]), 32'h0, "busy stuck");
  endtask
  task automatic rst_view();
    rd(`BCS_OFF_PC, 32'h0, "pc reset");
    rd(`BCS_OFF_CTRL, 32'h0, "ctrl reset");
    rd(`BCS_OFF_SHADOW, 32'h0, "shadow reset");
    $display("reset view test finished");
  endtask

  // ==========================================================================
  // Main sequence: reset view first, then table rows, then the awkward cases.
  initial begin
    rows[0] = '{16'he005, 16'h0, 21'h100, 8'h0, 8'h04, 8'h0, 8'h0,
      21'h10c, 8'h0, 8'h04, 8'h2, 8'h0, 21'h0, 24'h0};
    rows[1] = '{16'he005, 16'h0, 21'h100, 8'h0, 8'h1b, 8'h0, 8'h0,
      21'h102, 8'h0, 8'h1b, 8'h1, 8'h0, 21'h0, 24'h0};
    rows[2] = '{16'he080, 16'h0, 21'h1000, 8'h0, 8'h04, 8'h0, 8'h0,
      21'hf02, 8'h0, 8'h04, 8'h2, 8'h0, 21'h0, 24'h0};
    rows[3] = '{16'he07f, 16'h0, 21'h200, 8'h0, 8'h1f, 8'h0, 8'h0,
      21'h300, 8'h0, 8'h1f, 8'h2, 8'h0, 21'h0, 24'h0};
    rows[4] = '{16'h5a25, 16'h0, 21'h300, 8'h0d, 8'h01, 8'h05, 8'h19,
      21'h302, 8'h0d, 8'h01, 8'h1, 8'h0c, 21'h0, 24'h0};
    rows[5] = '{16'h5826, 16'h0, 21'h300, 8'h1a, 8'h00, 8'h05, 8'h1b,
      21'h302, 8'h00, 8'h07, 8'h1, 8'h1b, 21'h0, 24'h0};
    rows[6] = '{16'h5a27, 16'h0, 21'h300, 8'h0e, 8'h01, 8'h0, 8'h03,
      21'h302, 8'h0e, 8'h10, 8'h1, 8'hf5, 21'h0, 24'h0};
    rows[7] = '{16'h5940, 16'h0, 21'h300, 8'h01, 8'h01, 8'h03, 8'h80,
      21'h302, 8'h7f, 8'h09, 8'h1, 8'h80, 21'h0, 24'h0};
    rows[8] = '{16'hedff, 16'hffff, 21'h400, 8'h5a, 8'h13, 8'h07, 8'h0,
      21'h1ffffe, 8'h5a, 8'h13, 8'h2, 8'h0, 21'h404, 24'h07135a};
    rows[9] = '{16'hec45, 16'hf123, 21'h0ffffc, 8'h11, 8'h02, 8'h01, 8'h0,
      21'h2468a, 8'h11, 8'h02, 8'h2, 8'h0, 21'h100000, 24'h07135a};
    repeat (16) @(posedge CLK_IN);
    RESETN_IN <= 1'b1;
    @(posedge CLK_IN);
    rst_view();
    foreach (rows[i]) begin
      r = rows[i];
      da = r.ins[8] ? {r.bk[3:0], r.ins[7:0]} : {4'h0, r.ins[7:0]};
      wr(`BCS_OFF_PC, 32'(r.pc));
      wr(`BCS_OFF_WREG, 32'(r.w));
      wr(`BCS_OFF_FLAGS, 32'(r.fl));
      wr(`BCS_OFF_BANK, 32'(r.bk));
      wr(`BCS_OFF_DADDR, 32'(da));
      wr(`BCS_OFF_DDATA, 32'(r.dd));
      run(r.ins, r.ins2);
      rd(`BCS_OFF_PC, 32'(r.epc), "pc");
      rd(`BCS_OFF_WREG, 32'(r.ew), "w");
      rd(`BCS_OFF_FLAGS, 32'(r.efl), "flags");
      rd(`BCS_OFF_CYCLES, 32'(r.ecy), "cycles");
      rd(`BCS_OFF_DDATA, 32'(r.edd), "file");
      if (r.ins[15:9] == 7'h76) begin
        rd(`BCS_OFF_TOS, 32'(r.etos), "return");
        rd(`BCS_OFF_SHADOW, 32'(r.esh), "shadow");
      end
      $display("row %0d finished", i);
    end
    // An unknown opcode only steps the counter and raises the sticky flag.
    wr(`BCS_OFF_PC, 32'h500);
    run(16'h0000, 16'h0);
    rd(`BCS_OFF_PC, 32'h502, "bad op pc");
    rd(`BCS_OFF_CTRL, 32'h2, "bad op flag");
    // Two pushes came from the table; fill to the brim, then one more.
    for (int k = 0; k < DEPTH - 2; k++) run(16'hec00, 16'hf000);
    rd(`BCS_OFF_CTRL, 32'h0, "stack full");
    run(16'hec00, 16'hf000);
    rd(`BCS_OFF_CTRL, 32'h4, "stack overflow");
    $display("stack test finished");
    // Back-to-back write then read, then refused accesses.
    apb(1'b1, `BCS_OFF_WREG, 32'h33);
    apb(1'b0, `BCS_OFF_WREG, 32'h0);
    idle();
    chk(q, 32'h33, "back to back");
    apb(1'b0, 8'h30, 32'h0);
    idle();
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    apb(1'b1, 8'h11, 32'hff);
    idle();
    chk({31'h0, e}, 32'h1, "unaligned error");
    rd(`BCS_OFF_WREG, 32'h33, "unaligned write leaked");
    $display("bus test finished");
    // A second reset must clear the shadows and the sticky bits.
    RESETN_IN <= 1'b0;
    repeat (16) @(posedge CLK_IN);
    RESETN_IN <= 1'b1;
    @(posedge CLK_IN);
    rst_view();
    conclude();
  end
endmodule

bind bcs_exec bcs_exec_monitor i_bcs_exec_monitor (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT));
`default_nettype wire
